/* File: core/hdcr_heater_regs.sv */
/*
 * Register bank of the heater driver, reached by a two-wire serial slave,
 * with the heater drive comparator and the auxiliary converter controls.
 * Assumes scl and sda are already synchronous to clk_in and slow against it.
 * Each serial clock level must last at least two clk_in cycles.
 * Stored contents survive rst_n_in; only power-up restores the factory image.
 */
`timescale 1ns/10ps
module hdcr_heater_regs #(
  parameter int unsigned NV_WRITE_CYCLES = hdcr_pkg::NV_WRITE_CYCLES,
  parameter logic [7:0] DEVICE_ID = 8'h5a, // Arbitrary value.
  parameter logic [7:0] RESISTOR_ERROR = 8'h00
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic [11:0] sensed_current_input_in,
  output logic heater_drive_output_out,
  output logic [11:0] limit_threshold_mv_out,
  output logic [2:0] coarse_window_select_out,
  output logic [7:0] fine_setpoint_code_out,
  output logic [4:0] loop_gain_code_out,
  output logic aux_enable_out,
  output logic aux_gain_two_out,
  output logic [7:0] aux_code_out,
  output logic busy_out
);
  import hdcr_pkg::*;

  // Serial slave state, bit counter, shift register and register pointer.

  hdcr_state_t state_ff, nxt_state;
  logic [3:0] bit_cnt_ff, nxt_bit_cnt;
  logic [7:0] shift_ff, nxt_shift;
  logic [7:0] ptr_ff, nxt_ptr;
  logic rd_mode_ff, nxt_rd_mode;
  logic host_ack_ff, nxt_host_ack;
  logic oe_ff, nxt_oe;
  logic pend_ff, nxt_pend;
  logic [2:0] pend_addr_ff, nxt_pend_addr;
  logic [7:0] pend_data_ff, nxt_pend_data;

  // Input history for edge detection and the recall strobe after reset.
  logic scl_q_ff, sda_q_ff;
  logic recall_ff;

  // Select bit, volatile register image and registered drive outputs.
  logic sel_ff;
  logic [7:0] vol_ff [1:7];
  logic heater_ff;
  logic aux_en_ff, aux_gain_ff;
  logic [7:0] aux_code_ff;

  // Decoded bus events and register access strobes.
  logic scl_rise, scl_fall, bus_start, bus_stop;
  logic nv_busy, nv_req;
  logic [55:0] nv_image;
  logic ptr_in_nv, nv_target, byte_ok, byte_done, ack_done;
  logic vol_we, ctrl_we;
  logic [7:0] rd_byte;
  logic [11:0] limit_mv;

  // A START or STOP is a data edge while the clock stays high in both samples.
  assign scl_rise = scl_in && !scl_q_ff;
  assign scl_fall = !scl_in && scl_q_ff;
  assign bus_start = scl_in && scl_q_ff && sda_q_ff && !sda_in;
  assign bus_stop = scl_in && scl_q_ff && !sda_q_ff && sda_in;

  // Eight data bits end at the eighth fall; the acknowledge bit ends at the ninth.
  assign byte_done = scl_fall && (bit_cnt_ff == 4'd8);
  assign ack_done = scl_fall && (bit_cnt_ff == 4'd9);

  // Registers 01h to 06h have a writable stored copy; 00h, 07h and 08h do not.
  assign ptr_in_nv = (ptr_ff >= ADDR_LIMIT_WINDOW) && (ptr_ff <= ADDR_USER_TWO);
  assign nv_target = ptr_in_nv && !sel_ff;

  // Which received byte earns an acknowledge.
  assign byte_ok = (state_ff == ST_ID) ? (shift_ff[7:1] == SLAVE_ID) :
                   (state_ff == ST_ADDR) ? (shift_ff <= ADDR_CTRL) :
                   (state_ff == ST_WDATA) ? !(nv_target && (nv_busy || pend_ff)) :
                   1'b0;


  // The volatile copy takes a data byte at its acknowledge; storage waits for STOP.
  assign vol_we = byte_done && byte_ok && (state_ff == ST_WDATA);
  assign ctrl_we = vol_we && (ptr_ff == ADDR_CTRL);
  // A store starts only at the STOP that closes its own write.
  assign nv_req = bus_stop && pend_ff;

  // Reads come from the volatile side only.
  assign rd_byte = (ptr_ff == ADDR_ID) ? DEVICE_ID :
                   (ptr_ff == ADDR_CTRL) ? {sel_ff, 6'h00, nv_busy} :
                   (ptr_ff <= ADDR_RES_ERROR) ? vol_ff[ptr_ff[2:0]] :
                   8'h00;

  always_comb begin
    nxt_state = state_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_shift = shift_ff;
    nxt_ptr = ptr_ff;
    nxt_rd_mode = rd_mode_ff;
    nxt_host_ack = host_ack_ff;
    nxt_oe = oe_ff;
    nxt_pend = pend_ff && !nv_req;
    nxt_pend_addr = pend_addr_ff;
    nxt_pend_data = pend_data_ff;
    // The bus is held idle while the stored image is recalled.
    // A new START drops a pending store, so an abandoned write never reaches storage.
    if (recall_ff) begin
      nxt_state = ST_IDLE;
    end else if (bus_start) begin
      nxt_state = ST_ID;
      nxt_bit_cnt = 4'd0;
      nxt_oe = 1'b0;
      nxt_pend = 1'b0;
    // STOP ends any transfer; a pending store starts at the same edge.
    end else if (bus_stop) begin
      nxt_state = ST_IDLE;
      nxt_oe = 1'b0;
    end else if (state_ff != ST_IDLE) begin
      if (scl_rise) begin
        if (bit_cnt_ff < 4'd8) begin
          nxt_bit_cnt = bit_cnt_ff + 4'd1;
          if (state_ff != ST_RDATA) begin
            nxt_shift = {shift_ff[6:0], sda_in};
          end
        end else if (bit_cnt_ff == 4'd9 && state_ff == ST_RDATA) begin
          nxt_host_ack = !sda_in;
        end
      // Eighth fall: decide the acknowledge and take the byte.
      end else if (byte_done) begin
        nxt_bit_cnt = 4'd9;
        nxt_oe = 1'b0;
        if (state_ff != ST_RDATA) begin
          if (byte_ok) begin
            nxt_oe = 1'b1;
            if (state_ff == ST_ID) begin
              nxt_rd_mode = shift_ff[0];
            end else if (state_ff == ST_ADDR) begin
              nxt_ptr = shift_ff;
            end else if (nv_target) begin
              nxt_pend = 1'b1;
              nxt_pend_addr = ptr_ff[2:0];
              nxt_pend_data = shift_ff;
            end
          end else begin
            nxt_state = ST_IDLE;
            nxt_bit_cnt = 4'd0;
          end
        end
      // Ninth fall: release the wire or drive the first read bit; go to the next byte, or idle after write data or a host NACK.
      end else if (ack_done) begin
        nxt_bit_cnt = 4'd0;
        nxt_oe = 1'b0;
        if ((state_ff == ST_ID && rd_mode_ff) || (state_ff == ST_RDATA && host_ack_ff)) begin
          nxt_state = ST_RDATA;
          nxt_shift = rd_byte;
          nxt_oe = !rd_byte[7];
        end else if (state_ff == ST_ID) begin
          nxt_state = ST_ADDR;
        end else if (state_ff == ST_ADDR) begin
          nxt_state = ST_WDATA;
        end else begin
          nxt_state = ST_IDLE;
        end
      // Read bits change only while the serial clock is low.
      end else if (scl_fall && state_ff == ST_RDATA && bit_cnt_ff != 4'd0) begin
        nxt_shift = {shift_ff[6:0], 1'b0};
        nxt_oe = !shift_ff[6];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_ff <= ST_IDLE;
      bit_cnt_ff <= 4'd0;
      shift_ff <= 8'h00;
      ptr_ff <= 8'h00;
      rd_mode_ff <= 1'b0;
      host_ack_ff <= 1'b0;
      oe_ff <= 1'b0;
      pend_ff <= 1'b0;
      pend_addr_ff <= 3'h0;
      pend_data_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      bit_cnt_ff <= nxt_bit_cnt;
      shift_ff <= nxt_shift;
      ptr_ff <= nxt_ptr;
      rd_mode_ff <= nxt_rd_mode;
      host_ack_ff <= nxt_host_ack;
      oe_ff <= nxt_oe;
      pend_ff <= nxt_pend;
      pend_addr_ff <= nxt_pend_addr;
      pend_data_ff <= nxt_pend_data;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
      recall_ff <= 1'b1;
    end else begin
      scl_q_ff <= scl_in;
      sda_q_ff <= sda_in;
      recall_ff <= 1'b0;
    end
  end

  // The select bit is volatile only and never recalled.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sel_ff <= CTRL_RESET[SEL_BIT];
    end else if (ctrl_we) begin
      sel_ff <= shift_ff[SEL_BIT];
    end
  end

  // Each volatile register is reset, recalled or written by the bus, in that order.
  // Masked bits keep their old value on a bus write, but a recall loads the whole stored byte unmasked.
  genvar i;
  generate
    for (i = NV_FIRST; i <= NV_LAST; i++) begin : g_vol
      always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
          vol_ff[i] <= VOL_RESET[i];
        end else if (recall_ff) begin
          vol_ff[i] <= nv_image[(i - 1) * 8 +: 8];
        end else if (vol_we && ptr_ff == 8'(i)) begin
          vol_ff[i] <= (shift_ff & WRITE_MASK[i]) | (vol_ff[i] & ~WRITE_MASK[i]);
        end
      end
    end
  endgenerate

  // Stored copy of registers 01h to 07h and the store timer behind the busy flag.
  hdcr_nv_store #(
    .WRITE_CYCLES(NV_WRITE_CYCLES),
    .RESISTOR_ERROR(RESISTOR_ERROR)
  ) u_nv_store (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .wr_req_in(nv_req),
    .wr_addr_in(pend_addr_ff),
    .wr_data_in(pend_data_ff),
    .busy_out(nv_busy),
    .image_out(nv_image)
  );

  // Trip threshold as a voltage drop below supply, in millivolts.
  assign limit_mv = LIMIT_BASE_MV + 12'(vol_ff[1][LIMIT_MSB:LIMIT_LSB]) * LIMIT_STEP_MV;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      heater_ff <= 1'b0;
      aux_en_ff <= 1'b0;
      aux_gain_ff <= 1'b0;
      aux_code_ff <= 8'h00;
    end else begin
      // The drop across the sense resistor beyond the limit means the pin is below threshold.
      heater_ff <= (sensed_current_input_in > limit_mv);
      aux_en_ff <= vol_ff[3][AUX_EN_BIT];
      aux_gain_ff <= vol_ff[3][AUX_EN_BIT] && vol_ff[3][AUX_GAIN_BIT];
      aux_code_ff <= vol_ff[3][AUX_EN_BIT] ? vol_ff[4] : 8'h00;
    end
  end

  // The data pin is open drain: it only ever pulls low, under sda_oe_out.
  assign sda_out = 1'b0;
  assign sda_oe_out = oe_ff;
  assign heater_drive_output_out = heater_ff;
  assign limit_threshold_mv_out = limit_mv;
  assign coarse_window_select_out = vol_ff[1][WINDOW_MSB:0];
  assign fine_setpoint_code_out = vol_ff[2];
  assign loop_gain_code_out = vol_ff[3][GAIN_MSB:0];
  assign aux_enable_out = aux_en_ff;
  assign aux_gain_two_out = aux_gain_ff;
  assign aux_code_out = aux_code_ff;
  assign busy_out = nv_busy;

endmodule

/* File: core/hdcr_nv_store.sv */
/*
 * Non-volatile copy of registers 1 to 7 with its timed write cycle.
 * Assumes the caller only requests a write while busy is low.
 */
`timescale 1ns/10ps
module hdcr_nv_store #(
  parameter int unsigned WRITE_CYCLES = hdcr_pkg::NV_WRITE_CYCLES,
  parameter logic [7:0] RESISTOR_ERROR = 8'h00
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic wr_req_in,
  input wire logic [2:0] wr_addr_in,
  input wire logic [7:0] wr_data_in,
  output logic busy_out,
  output logic [55:0] image_out
);
  import hdcr_pkg::*;

  // Contents survive reset; only power-up gives the factory image.
  logic [7:0] mem_ff [1:7] = '{VOL_RESET[1], VOL_RESET[2], VOL_RESET[3], VOL_RESET[4],
                               VOL_RESET[5], VOL_RESET[6], RESISTOR_ERROR};
  logic [19:0] count_ff;
  logic [19:0] nxt_count;
  logic start_wr;

  assign start_wr = wr_req_in && (count_ff == 20'h0_0000);
  assign busy_out = (count_ff != 20'h0_0000);

  always_comb begin
    nxt_count = count_ff;
    if (start_wr) begin
      nxt_count = 20'(WRITE_CYCLES);
    end else if (count_ff != 20'h0_0000) begin
      nxt_count = count_ff - 20'h0_0001;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      count_ff <= 20'h0_0000;
    end else begin
      count_ff <= nxt_count;
    end
  end

  always_ff @(posedge clk_in) begin
    if (start_wr && (wr_addr_in != 3'h0) && (wr_addr_in != 3'h7)) begin
      mem_ff[wr_addr_in] <= wr_data_in;
    end
  end

  genvar i;
  generate
    for (i = NV_FIRST; i <= NV_LAST; i++) begin : g_image
      assign image_out[(i - 1) * 8 +: 8] = mem_ff[i];
    end
  endgenerate

endmodule

/* File: pkg/hdcr_pkg.sv */
/*
 * Constants of the heater driver configuration register bank: register
 * offsets, field positions, reset values, serial slave identity and timing.
 * Assumes a single 50 MHz clock shared by every user of this package.
 */
package hdcr_pkg;

  localparam logic [7:0] ADDR_ID = 8'h00;
  localparam logic [7:0] ADDR_LIMIT_WINDOW = 8'h01;
  localparam logic [7:0] ADDR_FINE = 8'h02;
  localparam logic [7:0] ADDR_GAIN_AUX = 8'h03;
  localparam logic [7:0] ADDR_AUX_CODE = 8'h04;
  localparam logic [7:0] ADDR_USER_ONE = 8'h05;
  localparam logic [7:0] ADDR_USER_TWO = 8'h06;
  localparam logic [7:0] ADDR_RES_ERROR = 8'h07;
  localparam logic [7:0] ADDR_CTRL = 8'h08;

  localparam int NV_FIRST = 1;
  localparam int NV_LAST = 7;

  localparam int LIMIT_LSB = 3;
  localparam int LIMIT_MSB = 7;
  localparam int WINDOW_MSB = 2;
  localparam int GAIN_MSB = 4;
  localparam int AUX_EN_BIT = 7;
  localparam int AUX_GAIN_BIT = 6;
  localparam int SEL_BIT = 7;
  localparam int BUSY_BIT = 0;

  // Volatile reset values, index 1 to 7.
  localparam logic [7:0] VOL_RESET [1:7] = '{8'h03, 8'h80, 8'h90, 8'h80, 8'h00, 8'h00, 8'h00};
  // Writable bits per register; bit 5 of the gain register and the error register are not writable.
  localparam logic [7:0] WRITE_MASK [1:7] = '{8'hff, 8'hff, 8'hdf, 8'hff, 8'hff, 8'hff, 8'h00};
  localparam logic [7:0] CTRL_RESET = 8'h00;

  localparam logic [6:0] SLAVE_ID = 7'h28;

  localparam logic [11:0] LIMIT_BASE_MV = 12'd200;
  localparam logic [11:0] LIMIT_STEP_MV = 12'd50;

  localparam int CLK_HZ = 50_000_000;
  localparam int NV_WRITE_MS = 20;
  localparam int NV_WRITE_CYCLES = NV_WRITE_MS * (CLK_HZ / 1000);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ID = 3'b001,
    ST_ADDR = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100
  } hdcr_state_t;

endpackage

/* File: tb/hdcr_heater_regs_tb.sv */
/* Self-checking bench of the heater register bank driven by a bus host model.
   Assumes the host model and the bank share the 50 MHz clock. */
`timescale 1ns/10ps
module hdcr_heater_regs_tb;
  import hdcr_pkg::*;
  localparam int unsigned NV_CYC = 1000;
  localparam logic [23:0] ROWS [0:10] = '{24'h08ff80, 24'h01a5a5, 24'h023c3c, 24'h03ffdf, 24'h045a5a,
    24'h051111, 24'h06eeee, 24'h077700, 24'h031010, 24'h035050, 24'h038080};
  logic clk_in = 1'b0;
  logic rst_n_in;
  logic [11:0] sense = 12'd0;
  logic scl, host_low, oe, sda_dev, heat, en, g2, busy, ok;
  logic [11:0] thr;
  logic [2:0] cw, a;
  logic [7:0] fine, code, q;
  logic [4:0] gain;
  logic [7:0] sh [1:7];
  int failures = 0;
  int checks = 0;
  wire logic sda = !host_low && (oe !== 1'b1 || sda_dev === 1'b1);
  always #10 clk_in = ~clk_in;
  hdcr_heater_regs #(.NV_WRITE_CYCLES(NV_CYC)) u_hdcr_heater_regs (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_dev), .sda_oe_out(oe), .sensed_current_input_in(sense),
    .heater_drive_output_out(heat), .limit_threshold_mv_out(thr), .coarse_window_select_out(cw),
    .fine_setpoint_code_out(fine), .loop_gain_code_out(gain), .aux_enable_out(en), .aux_gain_two_out(g2),
    .aux_code_out(code), .busy_out(busy));
  hdcr_host_model u_hdcr_host_model (.clk_in(clk_in), .sda_in(sda), .scl_out(scl), .sda_low_out(host_low));
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic outs();
    chk(thr, 12'd200 + 12'd50 * sh[1][7:3]);
    chk(cw, sh[1][2:0]);
    chk(fine, sh[2]);
    chk(gain, sh[3][4:0]);
    chk({en, g2}, {sh[3][7], sh[3][7] & sh[3][6]});
    chk(code, sh[3][7] ? sh[4] : 8'h00);
  endtask
  task automatic rdc(input logic [7:0] ad, input logic [7:0] exp);
    u_hdcr_host_model.rd(ad, q, ok);
    chk(ok, 1'b1);
    chk(q, exp);
  endtask
  task automatic do_reset();
    rst_n_in = 1'b0;
    repeat (20) @(posedge clk_in);
    #1 rst_n_in = 1'b1;
    repeat (4) @(posedge clk_in);
    #1;
  endtask
  task automatic close_out();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    do_reset();
    for (int i = 1; i < 8; i++) begin
      sh[i] = VOL_RESET[i];
    end
    outs();
    for (int i = 1; i < 9; i++) begin
      rdc(i[7:0], i < 8 ? sh[i] : 8'h00);
    end
    for (int i = 0; i < 11; i++) begin
      u_hdcr_host_model.wr(ROWS[i][23:16], ROWS[i][15:8], a);
      chk(a, 3'b111);
      if (ROWS[i][23:16] < 8'h08) begin
        sh[ROWS[i][23:16]] = ROWS[i][7:0];
      end
      rdc(ROWS[i][23:16], ROWS[i][7:0]);
      outs();
    end
    sense = thr + 12'd1;
    repeat (3) @(posedge clk_in);
    #1 chk(heat, 1'b1);
    sense = thr;
    repeat (3) @(posedge clk_in);
    #1 chk(heat, 1'b0);
    u_hdcr_host_model.wr(8'h09, 8'h12, a);
    chk(a, 3'b100);
    u_hdcr_host_model.wr(8'h08, 8'h00, a);
    u_hdcr_host_model.wr(8'h05, 8'hc3, a);
    chk(busy, 1'b1);
    u_hdcr_host_model.wr(8'h06, 8'h99, a);
    chk(a, 3'b110);
    u_hdcr_host_model.rd(8'h08, q, ok);
    chk(q, 8'h01);
    for (int n = 0; n < 10 && q !== 8'h00; n++) begin
      u_hdcr_host_model.rd(8'h08, q, ok);
    end
    chk(q, 8'h00);
    if (q !== 8'h00) begin
      close_out();
    end
    rdc(8'h05, 8'hc3);
    rdc(8'h06, 8'hee);
    do_reset();
    rdc(8'h05, 8'hc3);
    rdc(8'h06, 8'h00);
    rdc(8'h02, 8'h80);
    close_out();
  end
endmodule

/* File: tb/hdcr_host_model.sv */
/* Bus host model that drives the serial clock and pulls the data wire low.
   Assumes the bench resolves the data wire from both pull-downs. */
`timescale 1ns/10ps
module hdcr_host_model (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // The clock stays high four device clocks and low five, so the bank sees every level at least twice.
  task automatic bit_x(input logic b, output logic s);
    sda_low_out = ~b;
    wt(4);
    scl_out = 1'b1;
    wt(2);
    s = sda_in;
    wt(2);
    scl_out = 1'b0;
    wt(1);
  endtask
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], q[i]);
    end
    bit_x(1'b1, ack);
    ack = ~ack;
  endtask
  task automatic start();
    sda_low_out = 1'b0;
    wt(4);
    scl_out = 1'b1;
    wt(4);
    sda_low_out = 1'b1;
    wt(4);
    scl_out = 1'b0;
    wt(1);
  endtask
  task automatic stop();
    sda_low_out = 1'b1;
    wt(4);
    scl_out = 1'b1;
    wt(4);
    sda_low_out = 1'b0;
    wt(4);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d, output logic [2:0] acks);
    logic [7:0] q;
    start();
    xfer({hdcr_pkg::SLAVE_ID, 1'b0}, q, acks[2]);
    xfer(ad, q, acks[1]);
    xfer(d, q, acks[0]);
    stop();
  endtask
  task automatic rd(input logic [7:0] ad, output logic [7:0] q, output logic ok);
    logic [3:0] k;
    start();
    xfer({hdcr_pkg::SLAVE_ID, 1'b0}, q, k[0]);
    xfer(ad, q, k[1]);
    start();
    xfer({hdcr_pkg::SLAVE_ID, 1'b1}, q, k[2]);
    xfer(8'hff, q, k[3]);
    stop();
    ok = &k[2:0];
  endtask
endmodule

/* File: tb/hdcr_regs_sva.sv */
/* Assertions on the ports of the heater register bank.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/10ps
module hdcr_regs_sva #(
  parameter int unsigned NV_WRITE_CYCLES = 50
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_oe_out,
  input wire logic [11:0] sensed_current_input_in,
  input wire logic heater_drive_output_out,
  input wire logic [11:0] limit_threshold_mv_out,
  input wire logic [2:0] coarse_window_select_out,
  input wire logic [7:0] fine_setpoint_code_out,
  input wire logic [4:0] loop_gain_code_out,
  input wire logic aux_enable_out,
  input wire logic aux_gain_two_out,
  input wire logic [7:0] aux_code_out,
  input wire logic busy_out
);
  logic [31:0] busy_cnt_ff;
  always_ff @(posedge clk_in) begin
    busy_cnt_ff <= (rst_n_in && busy_out) ? busy_cnt_ff + 32'd1 : 32'd0;
  end
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  thresh_grid_a: assert property (limit_threshold_mv_out >= 12'd200 &&
    limit_threshold_mv_out <= 12'd1750 && limit_threshold_mv_out % 12'd50 == 12'd0) else $error("threshold off grid");
  heater_follow_a: assert property ($past(rst_n_in) |->
    heater_drive_output_out == $past(sensed_current_input_in > limit_threshold_mv_out)) else $error("heater wrong");
  aux_off_a: assert property (!aux_enable_out |-> aux_code_out == 8'h00 && !aux_gain_two_out) else $error("aux on");
  busy_len_a: assert property ($fell(busy_out) |-> busy_cnt_ff == NV_WRITE_CYCLES) else $error("busy length");
  busy_max_a: assert property (busy_out |-> busy_cnt_ff < NV_WRITE_CYCLES) else $error("busy too long");
  busy_start_a: assert property ($rose(busy_out) |-> scl_in && sda_in) else $error("busy without stop");
  ack_clk_low_a: assert property ($changed(sda_oe_out) |-> !scl_in) else $error("data moved in clock high");
  reg_quiet_a: assert property ($past(rst_n_in, 2) &&
    $changed({coarse_window_select_out, fine_setpoint_code_out, loop_gain_code_out}) |-> !scl_in) else $error("reg moved");
endmodule
bind hdcr_heater_regs hdcr_regs_sva #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) u_hdcr_regs_sva (.clk_in, .rst_n_in,
  .scl_in, .sda_in, .sda_oe_out, .sensed_current_input_in, .heater_drive_output_out, .limit_threshold_mv_out,
  .coarse_window_select_out, .fine_setpoint_code_out, .loop_gain_code_out, .aux_enable_out, .aux_gain_two_out,
  .aux_code_out, .busy_out);
